// file: logic/uart_status_map.svh
`ifndef UART_STATUS_MAP_SVH
`define UART_STATUS_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_MODE 16'hFF50
`define IDX_RX_ERR 16'hFF53
`define IDX_TX_STAT 16'hFF55
`define IDX_CLK_SEL 16'hFF56
`define IDX_TX_BUF 16'hFF60
`define IDX_RX_BUF 16'hFF61

`define MODE_RESET 8'h01
`define CLK_SEL_RESET 4'h0
`define STATUS_RESET 8'h00

`define MODE_POWER_BIT 7
`define MODE_TX_BIT 6
`define MODE_RX_BIT 5
`define MODE_PAR_HI_BIT 4
`define MODE_PAR_LO_BIT 3

`define ERR_PARITY_BIT 2
`define ERR_FRAMING_BIT 1
`define ERR_OVERRUN_BIT 0
`define TX_BUF_FULL_BIT 1
`define TX_SHIFT_BUSY_BIT 0

`define SEL_MAX_DIV 4'hA
`define SEL_TIMER 4'hB

// Extra wait cycles before the acknowledge of an access.
`define ACK_WAIT_NORMAL 2'h0
`define ACK_WAIT_ERR 2'h1

`endif

// file: logic/uart_status_pkg.sv
package uart_status_pkg;
  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_ZERO = 2'b01,
    PAR_ODD = 2'b10,
    PAR_EVEN = 2'b11
  } parity_mode_type;
endpackage

// file: logic/clk_sel_if.sv
`timescale 1ns/10ps
interface clk_sel_if;
  logic [3:0] sel;
  logic run;
  logic tick;
  modport ctrl (output sel, output run, input tick);
  modport gen (input sel, input run, output tick);
endinterface

// file: logic/base_clock_gen.sv
`timescale 1ns/10ps
`include "uart_status_map.svh"
module base_clock_gen (
  input wire logic ref_clk_in, // Peripheral clock.
  input wire logic rst_n_in, // Asynchronous reset, active low.
  input wire logic timer_8bit_output_in, // Timer output, free phase.
  clk_sel_if.gen csel // Selector in, base-clock enable out.
);
  import uart_status_pkg::*;

  logic [9:0] div_cnt;
  logic [9:0] mask;
  logic tmr_meta;
  logic tmr_sync;
  logic tmr_prev;
  logic div_hit;
  logic tmr_edge;

  // The divider is never reset by a selector write, so rewriting the
  // same code leaves the base clock phase untouched.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt <= 10'h000;
    end else if (!csel.run) begin
      div_cnt <= 10'h000;
    end else begin
      div_cnt <= div_cnt + 10'h001;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tmr_meta <= 1'b0;
      tmr_sync <= 1'b0;
      tmr_prev <= 1'b0;
    end else begin
      tmr_meta <= timer_8bit_output_in;
      tmr_sync <= tmr_meta;
      tmr_prev <= tmr_sync;
    end
  end

  always_comb begin
    mask = 10'(({1'b0, 10'h000} | 11'h001) << csel.sel) - 10'h001;
  end

  assign div_hit = (div_cnt & mask) == mask;
  assign tmr_edge = tmr_sync & ~tmr_prev;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      csel.tick <= 1'b0;
    end else if (!csel.run) begin
      csel.tick <= 1'b0;
    end else if (csel.sel <= `SEL_MAX_DIV) begin
      csel.tick <= div_hit;
    end else if (csel.sel == `SEL_TIMER) begin
      csel.tick <= tmr_edge;
    end else begin
      csel.tick <= 1'b0;
    end
  end

  a_div_half_rate: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    csel.run && csel.sel == 4'h1 && $stable(csel.sel) && csel.tick
    |=> !csel.tick)
    else $error("divide-by-two base clock ticked twice in a row");

  a_sel_prohibit: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    csel.sel > `SEL_TIMER |=> !csel.tick)
    else $error("prohibited selector code produced a tick");

  a_timer_edge: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    csel.run && csel.sel == `SEL_TIMER && tmr_sync && !tmr_prev
    |=> csel.tick)
    else $error("timer edge did not give a base clock tick");
endmodule

// file: logic/uart_status.sv
`timescale 1ns/10ps
`include "uart_status_map.svh"
module uart_status (
  input wire logic ref_clk_in, // Peripheral clock, 125 MHz.
  input wire logic rst_n_in, // Asynchronous reset, active low.
  input wire logic [17:0] avs_address_in, // Byte address.
  input wire logic avs_read_in, // Read request.
  input wire logic avs_write_in, // Write request.
  input wire logic [31:0] avs_writedata_in, // Write data.
  input wire logic [3:0] avs_byteenable_in, // Byte enables.
  output logic [31:0] avs_readdata_out, // Read data.
  output logic avs_waitrequest_out, // Wait request.
  input wire logic rx_frame_done_in, // Reception complete pulse.
  input wire logic [7:0] rx_char_in, // Received character.
  input wire logic rx_parity_bit_in, // Received parity bit.
  input wire logic rx_stop_bit_in, // First stop bit sample.
  input wire logic tx_frame_done_in, // Frame sent pulse.
  input wire logic timer_8bit_output_in, // Timer output.
  output logic tx_load_out, // Shift register load pulse.
  output logic [7:0] tx_shift_register_out, // Byte to shift out.
  output logic base_clock_tick_out, // Base clock enable.
  output logic power_enable_out, // Power enable.
  output logic transmit_enable_out, // Transmit enable.
  output logic receive_enable_out, // Receive enable.
  output uart_status_pkg::parity_mode_type parity_mode_out // Parity mode.
);
  import uart_status_pkg::*;

  logic [7:0] mode;
  logic [3:0] clk_sel;
  logic [2:0] err_flags;
  logic [7:0] rx_buffer;
  logic rx_full;
  logic [7:0] tx_buffer;
  logic buf_full;
  logic shift_busy;
  logic [1:0] wait_cnt;
  logic [1:0] need_wait;
  logic [15:0] idx;
  logic req;
  logic accept;
  logic rd;
  logic wr;
  logic err_rd;
  logic rxbuf_rd;
  logic tx_wr;
  logic rx_active;
  logic tx_active;
  logic par_err;
  logic load;
  logic [2:0] err_set;
  logic [7:0] rd_mux;
  parity_mode_type par_mode;

  clk_sel_if csel ();

  assign csel.sel = clk_sel;
  assign csel.run = mode[`MODE_POWER_BIT];
  assign base_clock_tick_out = csel.tick;

  base_clock_gen u_clk_gen (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .timer_8bit_output_in(timer_8bit_output_in),
    .csel(csel)
  );

  assign par_mode = parity_mode_type'(
    mode[`MODE_PAR_HI_BIT:`MODE_PAR_LO_BIT]);
  assign power_enable_out = mode[`MODE_POWER_BIT];
  assign transmit_enable_out = mode[`MODE_TX_BIT];
  assign receive_enable_out = mode[`MODE_RX_BIT];
  assign parity_mode_out = par_mode;
  assign rx_active = mode[`MODE_POWER_BIT] & mode[`MODE_RX_BIT];
  assign tx_active = mode[`MODE_POWER_BIT] & mode[`MODE_TX_BIT];

  assign idx = avs_address_in[17:2];
  assign req = avs_read_in | avs_write_in;
  assign need_wait = (avs_read_in && idx == `IDX_RX_ERR) ?
    `ACK_WAIT_ERR : `ACK_WAIT_NORMAL;
  assign accept = req & avs_waitrequest_out & (wait_cnt == need_wait);
  assign rd = accept & avs_read_in;
  assign wr = accept & avs_write_in & avs_byteenable_in[0];
  assign err_rd = rd & (idx == `IDX_RX_ERR);
  assign rxbuf_rd = rd & (idx == `IDX_RX_BUF);
  assign tx_wr = wr & (idx == `IDX_TX_BUF) & tx_active;

  // Wait request idles high so that every output stays a flip-flop; the
  // cost is one cycle of latency on each access.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_waitrequest_out <= 1'b1;
      wait_cnt <= 2'h0;
    end else if (!avs_waitrequest_out) begin
      avs_waitrequest_out <= 1'b1;
      wait_cnt <= 2'h0;
    end else if (accept) begin
      avs_waitrequest_out <= 1'b0;
    end else if (req) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end

  // register read-back, fields narrower than a byte with zero upper bits
  always_comb begin
    case (idx)
      `IDX_MODE: rd_mux = mode;
      `IDX_RX_ERR: rd_mux = {5'h00, err_flags};
      `IDX_TX_STAT: rd_mux = {6'h00, buf_full, shift_busy};
      `IDX_CLK_SEL: rd_mux = {4'h0, clk_sel};
      `IDX_RX_BUF: rd_mux = rx_buffer;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (rd) begin
      avs_readdata_out <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode <= `MODE_RESET;
    end else if (wr && idx == `IDX_MODE) begin
      mode <= avs_writedata_in[7:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_sel <= `CLK_SEL_RESET;
    end else if (wr && idx == `IDX_CLK_SEL) begin
      clk_sel <= avs_writedata_in[3:0];
    end
  end

  always_comb begin
    unique case (par_mode)
      PAR_NONE: par_err = 1'b0;
      PAR_ZERO: par_err = 1'b0;
      PAR_ODD: par_err = ~^{rx_char_in, rx_parity_bit_in};
      PAR_EVEN: par_err = ^{rx_char_in, rx_parity_bit_in};
    endcase
  end

  // parity, framing on first stop bit, overrun
  assign err_set = {par_err, ~rx_stop_bit_in, rx_full} &
    {3{rx_frame_done_in}};

  // clear on disable or status read, a new error wins over the read
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err_flags <= 3'h0;
    end else if (!rx_active) begin
      err_flags <= 3'h0;
    end else begin
      err_flags <= err_set | (err_rd ? 3'h0 : err_flags);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_buffer <= 8'h00;
      rx_full <= 1'b0;
    end else if (!rx_active) begin
      rx_buffer <= 8'h00;
      rx_full <= 1'b0;
    end else if (rx_frame_done_in && !rx_full) begin
      rx_buffer <= rx_char_in;
      rx_full <= 1'b1;
    end else if (rxbuf_rd) begin
      rx_full <= 1'b0;
    end
  end

  // load at frame end for gap-free output
  assign load = buf_full & (~shift_busy | tx_frame_done_in);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_buffer <= 8'h00;
    end else if (tx_wr) begin
      tx_buffer <= avs_writedata_in[7:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      buf_full <= 1'b0;
    end else if (!tx_active) begin
      buf_full <= 1'b0;
    end else if (tx_wr) begin
      buf_full <= 1'b1;
    end else if (load) begin
      buf_full <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_busy <= 1'b0;
    end else if (!tx_active) begin
      shift_busy <= 1'b0;
    end else if (load) begin
      shift_busy <= 1'b1;
    end else if (tx_frame_done_in) begin
      shift_busy <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_load_out <= 1'b0;
      tx_shift_register_out <= 8'h00;
    end else begin
      tx_load_out <= load & tx_active;
      if (load && tx_active) begin
        tx_shift_register_out <= tx_buffer;
      end
    end
  end

  a_parity_set: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    rx_active && rx_frame_done_in && par_err
    |=> err_flags[`ERR_PARITY_BIT])
    else $error("parity error flag not set");

  a_parity_by_mode: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    $rose(err_flags[`ERR_PARITY_BIT])
    |-> $past(par_mode) == PAR_ODD || $past(par_mode) == PAR_EVEN)
    else $error("parity flag set outside odd or even mode");

  a_framing_set: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    rx_active && rx_frame_done_in && !rx_stop_bit_in
    |=> err_flags[`ERR_FRAMING_BIT])
    else $error("framing error flag not set");

  a_overrun_drop: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    rx_active && rx_frame_done_in && rx_full
    |=> err_flags[`ERR_OVERRUN_BIT] && $stable(rx_buffer))
    else $error("overrun not flagged or buffer overwritten");

  a_err_clear: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    !rx_active || (err_rd && !rx_frame_done_in) |=> err_flags == 3'h0)
    else $error("receive error flags not cleared");

  a_err_wait: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    avs_read_in && idx == `IDX_RX_ERR && avs_waitrequest_out &&
    wait_cnt == 2'h0 |=> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("error status read did not take one extra wait");

  a_tx_clear: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    !tx_active |=> !buf_full && !shift_busy)
    else $error("transmit status not cleared when disabled");

  a_buf_full: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    tx_wr |=> buf_full ##1 (!buf_full || !tx_active || shift_busy))
    else $error("buffer-full flag wrong after buffer write");

  a_shift_load: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    load && tx_active |=> shift_busy && tx_load_out &&
    tx_shift_register_out == $past(tx_buffer))
    else $error("load did not mark shift register busy");

  a_gap_free: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    tx_active && shift_busy && buf_full && tx_frame_done_in
    |=> tx_load_out && shift_busy)
    else $error("buffered byte did not follow without gap");

  a_tx_reserved: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    rd && idx == `IDX_TX_STAT |=> avs_readdata_out[31:2] == 30'h0)
    else $error("transmit status upper bits not zero");

  c_overrun: cover property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    rx_active && rx_frame_done_in && rx_full);

  c_back_to_back: cover property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    tx_active && shift_busy && buf_full && tx_frame_done_in);

  c_err_read: cover property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    err_rd && err_flags != 3'h0);
endmodule

// file: tb/remote_uart_model.sv
`timescale 1ns/10ps
module remote_uart_model #(
  parameter int FRAME_CYCLES = 40
) (
  input wire logic ref_clk_in, // Peripheral clock.
  input wire logic rst_n_in, // Reset, active low.
  input wire logic tx_load_in, // Shift register load pulse.
  output logic tx_frame_done_out, // Frame sent pulse.
  output logic rx_frame_done_out, // Reception done pulse.
  output logic [7:0] rx_char_out, // Received character.
  output logic rx_parity_bit_out, // Received parity bit.
  output logic rx_stop_bit_out // First stop bit sample.
);
  int cnt;

  initial begin
    rx_frame_done_out = 1'b0;
    rx_char_out = 8'h00;
    rx_parity_bit_out = 1'b1;
    rx_stop_bit_out = 1'b0;
  end

  // Outside the done pulse the lines carry the inverse of the last value.
  // The block must never lean on a character that is no longer valid.
  task automatic send(input logic [7:0] c, input logic p, input logic s);
    @(posedge ref_clk_in);
    rx_frame_done_out <= 1'b1;
    rx_char_out <= c;
    rx_parity_bit_out <= p;
    rx_stop_bit_out <= s;
    @(posedge ref_clk_in);
    rx_frame_done_out <= 1'b0;
    rx_char_out <= ~c;
    rx_parity_bit_out <= ~p;
    rx_stop_bit_out <= ~s;
  endtask

  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 0;
      tx_frame_done_out <= 1'b0;
    end else begin
      tx_frame_done_out <= (cnt == 1);
      if (tx_load_in === 1'b1) begin
        cnt <= FRAME_CYCLES;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// file: tb/uart_status_tb_top.sv
`timescale 1ns/10ps
`include "uart_status_map.svh"
module uart_status_tb_top;
  import uart_status_pkg::*;
  logic clk, rst_n, rd, wr, timer, tx_load, tick, pwr, txe, rxe;
  logic wreq, tx_done, rx_done, rx_par, rx_stop;
  logic [17:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [3:0] be;
  logic [7:0] shift, rx_char;
  parity_mode_type pm;
  int num_errors = 0;
  int cmp_count = 0;
  int bus_cycles, t;

  uart_status uut (.ref_clk_in(clk), .rst_n_in(rst_n),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .rx_frame_done_in(rx_done), .rx_char_in(rx_char),
    .rx_parity_bit_in(rx_par), .rx_stop_bit_in(rx_stop),
    .tx_frame_done_in(tx_done), .timer_8bit_output_in(timer),
    .tx_load_out(tx_load), .tx_shift_register_out(shift),
    .base_clock_tick_out(tick), .power_enable_out(pwr),
    .transmit_enable_out(txe), .receive_enable_out(rxe),
    .parity_mode_out(pm));
  remote_uart_model #(.FRAME_CYCLES(40)) part (.ref_clk_in(clk),
    .rst_n_in(rst_n), .tx_load_in(tx_load), .tx_frame_done_out(tx_done),
    .rx_frame_done_out(rx_done), .rx_char_out(rx_char),
    .rx_parity_bit_out(rx_par), .rx_stop_bit_out(rx_stop));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // The request stands until waitrequest is sampled low at a rising edge.
  task automatic bus(input logic w, input logic [15:0] idx,
                     input logic [7:0] d);
    @(posedge clk);
    addr <= {idx, 2'b00};
    rd <= !w;
    wr <= w;
    wdata <= {24'h000000, d};
    bus_cycles = 0;
    do begin
      @(posedge clk);
      bus_cycles++;
    end while (wreq !== 1'b0 && bus_cycles < 20);
    if (wreq !== 1'b0) begin
      num_errors++;
      report_and_stop();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp,
                        input string name);
    bus(1'b0, idx, 8'h00);
    check(name, q, {24'h000000, exp});
  endtask

  task automatic count_ticks(input int cycles);
    t = 0;
    repeat (cycles) begin
      @(negedge clk);
      if (tick === 1'b1) t++;
    end
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tx_done !== 1'b1 && n < 200);
    if (tx_done !== 1'b1) begin
      num_errors++;
      report_and_stop();
    end
  endtask

  initial begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 18'h00000;
    wdata = 32'h00000000;
    be = 4'hF;
    timer = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(`IDX_RX_ERR, 8'h00, "error status reset");
    check("error status wait", bus_cycles, 3);
    rd_chk(`IDX_TX_STAT, 8'h00, "tx status reset");
    rd_chk(`IDX_CLK_SEL, 8'h00, "clock select reset");
    rd_chk(`IDX_MODE, `MODE_RESET, "mode reset");
    bus(1'b1, 16'hFF70, 8'h5A);
    rd_chk(16'hFF70, 8'h00, "unmapped");
    bus(1'b1, `IDX_TX_STAT, 8'hFF);
    rd_chk(`IDX_TX_STAT, 8'h00, "tx status write");
    for (int m = 0; m < 4; m++) begin
      for (int p = 0; p < 2; p++) begin
        bus(1'b1, `IDX_MODE, {3'b100, 2'(m), 3'b000});
        bus(1'b1, `IDX_MODE, {3'b111, 2'(m), 3'b000});
        part.send(8'h03, 1'(p), 1'b1);
        rd_chk(`IDX_RX_ERR, ((m == 2 && p == 0) || (m == 3 && p == 1)) ?
               8'h04 : 8'h00, "parity error");
        rd_chk(`IDX_RX_BUF, 8'h03, "rx buffer");
      end
    end
    check("mode outputs", {pwr, txe, rxe, pm}, 5'h1F);
    part.send(8'h55, 1'b0, 1'b0);
    rd_chk(`IDX_RX_ERR, 8'h02, "framing error");
    rd_chk(`IDX_RX_BUF, 8'h55, "rx buffer");
    part.send(8'h11, 1'b0, 1'b1);
    part.send(8'h22, 1'b0, 1'b1);
    rd_chk(`IDX_RX_ERR, 8'h01, "overrun error");
    rd_chk(`IDX_RX_BUF, 8'h11, "overrun buffer");
    rd_chk(`IDX_RX_ERR, 8'h00, "clear on read");
    part.send(8'h33, 1'b1, 1'b1);
    bus(1'b1, `IDX_MODE, 8'hD8);
    rd_chk(`IDX_RX_ERR, 8'h00, "receive off clear");
    bus(1'b1, `IDX_MODE, 8'hF8);
    bus(1'b0, `IDX_RX_BUF, 8'h00);
    part.send(8'h44, 1'b0, 1'b0);
    bus(1'b1, `IDX_MODE, 8'h00);
    bus(1'b1, `IDX_MODE, 8'hF8);
    rd_chk(`IDX_RX_ERR, 8'h00, "power off clear");
    bus(1'b0, `IDX_RX_BUF, 8'h00);
    for (int n = 0; n <= 10; n++) begin
      bus(1'b1, `IDX_CLK_SEL, 8'(n));
      count_ticks((1 << n) + 4);
      bus(1'b1, `IDX_CLK_SEL, 8'(n));
      count_ticks(2 << n);
      check("divided ticks", t, 2);
    end
    rd_chk(`IDX_CLK_SEL, 8'h0A, "clock select");
    bus(1'b1, `IDX_CLK_SEL, 8'h0B);
    t = 0;
    for (int i = 0; i < 72; i++) begin
      @(posedge clk);
      timer <= i[3];
      @(negedge clk);
      if (tick === 1'b1) t++;
    end
    check("timer ticks", t, 4);
    bus(1'b1, `IDX_CLK_SEL, 8'h0C);
    count_ticks(64);
    check("prohibited ticks", t, 0);
    bus(1'b1, `IDX_MODE, 8'hC0);
    bus(1'b1, `IDX_TX_BUF, 8'hA5);
    @(negedge clk);
    check("first load", {tx_load, shift}, 9'h1A5);
    rd_chk(`IDX_TX_STAT, 8'h01, "tx status busy");
    // Buffer flag read zero just above, so a second byte is allowed.
    bus(1'b1, `IDX_TX_BUF, 8'h5A);
    rd_chk(`IDX_TX_STAT, 8'h03, "tx status full");
    wait_done();
    @(negedge clk);
    check("gap free load", {tx_load, shift}, 9'h15A);
    rd_chk(`IDX_TX_STAT, 8'h01, "tx status moved");
    wait_done();
    repeat (2) @(negedge clk);
    rd_chk(`IDX_TX_STAT, 8'h00, "tx status idle");
    bus(1'b1, `IDX_TX_BUF, 8'h77);
    bus(1'b1, `IDX_MODE, 8'h80);
    rd_chk(`IDX_TX_STAT, 8'h00, "transmit off clear");
    report_and_stop();
  end
endmodule
